/* File: design/kfac_pkg.sv */
package kfac_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, word aligned)
  // ---------------------------------------------------------------
  localparam logic [5:0] REG_CMD = 6'h00;
  localparam logic [5:0] REG_DATA0 = 6'h04;
  localparam logic [5:0] REG_DATA1 = 6'h08;
  localparam logic [5:0] REG_RSP = 6'h0c;
  localparam logic [5:0] REG_RDAT0 = 6'h10;
  localparam logic [5:0] REG_RDAT1 = 6'h14;
  localparam logic [5:0] REG_CFG = 6'h18;
  localparam logic [5:0] REG_KEYS = 6'h1c;
  localparam logic [5:0] REG_SAVE = 6'h20;
  localparam logic [5:0] REG_FANPWR = 6'h24;
  localparam logic [5:0] REG_PULSE = 6'h28;
  // ---------------------------------------------------------------
  // command and response codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_DIRECT = 8'h16;
  localparam logic [7:0] CMD_KEYREP = 8'h17;
  localparam logic [7:0] CMD_POLL = 8'h18;
  localparam logic [7:0] CMD_FAILSAFE = 8'h19;
  localparam logic [7:0] CMD_GLITCH = 8'h1a;
  localparam logic [7:0] CMD_FANQ = 8'h1b;
  localparam logic [7:0] RSP_FLAG = 8'h40;
  localparam logic [7:0] RSP_ERROR = 8'hc0;
  // ---------------------------------------------------------------
  // key and fan bits
  // ---------------------------------------------------------------
  localparam logic [5:0] KEY_UP_BIT = 6'h01;
  localparam logic [5:0] KEY_CONFIRM_BIT = 6'h02;
  localparam logic [5:0] KEY_ABORT_BIT = 6'h04;
  localparam logic [5:0] KEY_WEST_BIT = 6'h08;
  localparam logic [5:0] KEY_EAST_BIT = 6'h10;
  localparam logic [5:0] KEY_SOUTH_BIT = 6'h20;
  localparam logic [7:0] KEY_MASK_MAX = 8'h3f;
  localparam logic [7:0] FAN_MASK_MAX = 8'h0f;
  localparam logic [7:0] GLITCH_MAX = 8'h64;
  localparam logic [7:0] GLITCH_RESET = 8'h01;
  localparam logic [7:0] PWR_FULL = 8'h64;
  // ---------------------------------------------------------------
  // switch option bits
  // ---------------------------------------------------------------
  localparam int AUTO_POL_BIT = 0;
  localparam int RST_HIGH_BIT = 1;
  localparam int PWR_HIGH_BIT = 2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int GLITCH_TICK_NS = 552500;
  localparam int GLITCH_TICK_CYC = GLITCH_TICK_NS / 20;
  localparam int FS_TICK_MS = 125;
  localparam int FS_TICK_CYC = (CLK_HZ / 1000) * FS_TICK_MS;
  localparam int PWM_STEPS = 100;
  localparam int PULSE_TICK_CYC = CLK_HZ / 32;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b10
  } kfac_state_t;
endpackage : kfac_pkg

/* File: design/kfac_top.sv */
`timescale 1ns/100ps
module kfac_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // keypad and display
  input wire logic [5:0] KEYS_I,
  output logic [7:0] LCD_CMD_O,
  output logic LCD_CMD_STB_O,
  output logic [5:0] KEY_EVENT_O,
  output logic KEY_EVENT_PRESS_O,
  output logic KEY_EVENT_STB_O,
  // fans
  output logic [3:0] FAN_PWM_O,
  input wire logic [3:0] FAN_TACH_I,
  output logic [3:0] FAN_TACH_EDGE_O,
  // power switch lines
  input wire logic HOST_ON_DETECT_I,
  output logic SUPPLY_PULSE_OUT_O,
  output logic SUPPLY_PULSE_OUT_OE_O,
  output logic RESTART_PULSE_OUT_O,
  output logic RESTART_PULSE_OUT_OE_O
);
  import kfac_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  kfac_state_t state_reg;
  logic [7:0] cmd_reg;
  logic [31:0] data0_reg;
  logic [7:0] rsp_reg;
  logic [31:0] rdat0_reg;
  logic [7:0] rdat1_reg;
  logic rsp_valid_reg;
  logic [5:0] press_mask_reg;
  logic [5:0] release_mask_reg;
  logic [5:0] keys_prev_reg;
  logic [5:0] hist_press_reg;
  logic [5:0] hist_release_reg;
  logic [3:0] fs_mask_reg;
  logic [7:0] fs_timeout_reg;
  logic [7:0] fs_count_reg;
  logic [31:0] fs_div_reg;
  logic fs_expired_reg;
  logic [7:0] fan_pwr_reg [4];
  logic [7:0] glitch_reg [4];
  logic [7:0] switch_opt_reg;
  logic [7:0] pulse_len_reg;
  logic [15:0] tick_div_reg;
  logic [6:0] pwm_step_reg;
  logic [31:0] pulse_div_reg;
  logic [7:0] pulse_cnt_reg;
  logic pulse_sel_reg;
  logic pulse_act_reg;
  logic host_sense_reg;
  logic rd_ack_reg;
  logic [7:0] arg0;
  logic [7:0] arg1;
  logic start_cmd;
  logic ok;
  logic tick;
  logic [5:0] pressed_now;
  logic [5:0] released_now;

  assign arg0 = data0_reg[7:0];
  assign arg1 = data0_reg[15:8];
  assign start_cmd = AVS_WRITE_I && (AVS_ADDRESS_I == REG_CMD) && state_reg == ST_IDLE;
  assign tick = (tick_div_reg == 16'(GLITCH_TICK_CYC - 1));
  assign pressed_now = KEYS_I & ~keys_prev_reg;
  assign released_now = ~KEYS_I & keys_prev_reg;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  // reads take one wait cycle; writes complete at once
  assign AVS_WAITREQUEST_O = AVS_READ_I && !rd_ack_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_ack_reg <= 1'b0;
      AVS_READDATA_O <= 32'h0;
    end else begin
      rd_ack_reg <= AVS_READ_I && !rd_ack_reg;
      // captured once per read so the data stands until the next read
      if (AVS_READ_I && !rd_ack_reg) begin
        case (AVS_ADDRESS_I)
          REG_CMD: AVS_READDATA_O <= {23'h0, rsp_valid_reg, cmd_reg};
          REG_DATA0: AVS_READDATA_O <= data0_reg;
          REG_RSP: AVS_READDATA_O <= {23'h0, rsp_valid_reg, rsp_reg};
          REG_RDAT0: AVS_READDATA_O <= rdat0_reg;
          REG_RDAT1: AVS_READDATA_O <= {24'h0, rdat1_reg};
          REG_CFG: AVS_READDATA_O <= {8'h0, pulse_len_reg, switch_opt_reg, 2'h0, release_mask_reg};
          REG_KEYS: AVS_READDATA_O <= {18'h0, press_mask_reg, 2'h0, KEYS_I};
          REG_SAVE: AVS_READDATA_O <= {glitch_reg[3], glitch_reg[2], glitch_reg[1], glitch_reg[0]};
          REG_FANPWR: AVS_READDATA_O <= {fan_pwr_reg[3], fan_pwr_reg[2], fan_pwr_reg[1], fan_pwr_reg[0]};
          REG_PULSE: AVS_READDATA_O <= {30'h0, pulse_sel_reg, pulse_act_reg};
          default: AVS_READDATA_O <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      data0_reg <= 32'h0;
    end else if (AVS_WRITE_I && AVS_ADDRESS_I == REG_DATA0) begin
      data0_reg <= AVS_WRITEDATA_I;
    end
  end

  // ---------------------------------------------------------------
  // command engine
  // ---------------------------------------------------------------
  always_comb begin
    case (cmd_reg)
      CMD_DIRECT, CMD_POLL, CMD_FANQ: ok = 1'b1;
      CMD_KEYREP: ok = arg0 <= KEY_MASK_MAX && arg1 <= KEY_MASK_MAX;
      CMD_FAILSAFE: ok = arg0 >= 8'h01 && arg0 <= FAN_MASK_MAX;
      CMD_GLITCH: ok = data0_reg[7:0] <= GLITCH_MAX && data0_reg[15:8] <= GLITCH_MAX
                     && data0_reg[23:16] <= GLITCH_MAX && data0_reg[31:24] <= GLITCH_MAX;
      default: ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 8'h0;
      rsp_reg <= 8'h0;
      rsp_valid_reg <= 1'b0;
      rdat0_reg <= 32'h0;
      rdat1_reg <= 8'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_cmd) begin
            cmd_reg <= AVS_WRITEDATA_I[7:0];
            rsp_valid_reg <= 1'b0;
            state_reg <= ST_EXEC;
          end else if (AVS_WRITE_I && AVS_ADDRESS_I == REG_RSP) begin
            rsp_valid_reg <= 1'b0;
          end
        end
        ST_EXEC: begin
          rdat0_reg <= 32'h0;
          rdat1_reg <= 8'h0;
          if (cmd_reg == CMD_POLL) begin
            rdat0_reg <= {8'h0, 2'h0, hist_release_reg | released_now, 2'h0,
                          hist_press_reg | pressed_now, 2'h0, KEYS_I};
          end else if (cmd_reg == CMD_FANQ) begin
            rdat0_reg <= {fan_pwr_reg[3], fan_pwr_reg[2], fan_pwr_reg[1], fan_pwr_reg[0]};
            rdat1_reg <= {4'h0, fs_mask_reg};
          end
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          rsp_reg <= ok ? (cmd_reg | RSP_FLAG) : RSP_ERROR;
          rsp_valid_reg <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // display pass-through
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LCD_CMD_O <= 8'h0;
      LCD_CMD_STB_O <= 1'b0;
    end else begin
      LCD_CMD_STB_O <= state_reg == ST_EXEC && cmd_reg == CMD_DIRECT;
      if (state_reg == ST_EXEC && cmd_reg == CMD_DIRECT) begin
        LCD_CMD_O <= arg0;
      end
    end
  end

  // ---------------------------------------------------------------
  // keypad
  // ---------------------------------------------------------------
  // boot-state store: a real part loads this from non-volatile memory
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      press_mask_reg <= KEY_MASK_MAX[5:0];
      release_mask_reg <= KEY_MASK_MAX[5:0];
    end else if (state_reg == ST_EXEC && cmd_reg == CMD_KEYREP && ok) begin
      press_mask_reg <= arg0[5:0];
      release_mask_reg <= arg1[5:0];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      keys_prev_reg <= 6'h0;
      hist_press_reg <= 6'h0;
      hist_release_reg <= 6'h0;
    end else begin
      keys_prev_reg <= KEYS_I;
      if (state_reg == ST_EXEC && cmd_reg == CMD_POLL) begin
        hist_press_reg <= 6'h0;
        hist_release_reg <= 6'h0;
      end else begin
        hist_press_reg <= hist_press_reg | pressed_now;
        hist_release_reg <= hist_release_reg | released_now;
      end
    end
  end

  // one report per cycle; simultaneous events favour presses, all keys of the winning kind in one mask
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      KEY_EVENT_O <= 6'h0;
      KEY_EVENT_PRESS_O <= 1'b0;
      KEY_EVENT_STB_O <= 1'b0;
    end else begin
      KEY_EVENT_STB_O <= |(pressed_now & press_mask_reg) || |(released_now & release_mask_reg);
      KEY_EVENT_PRESS_O <= |(pressed_now & press_mask_reg);
      KEY_EVENT_O <= (|(pressed_now & press_mask_reg)) ? pressed_now & press_mask_reg
                                                      : released_now & release_mask_reg;
    end
  end

  // ---------------------------------------------------------------
  // fan fail-safe
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fs_mask_reg <= 4'h0;
      fs_timeout_reg <= 8'h0;
      fs_count_reg <= 8'h0;
      fs_div_reg <= 32'h0;
      fs_expired_reg <= 1'b0;
    end else begin
      if (state_reg == ST_EXEC && cmd_reg == CMD_FAILSAFE && ok) begin
        fs_mask_reg <= arg0[3:0];
        fs_timeout_reg <= arg1;
        fs_count_reg <= arg1;
        fs_div_reg <= 32'h0;
        fs_expired_reg <= 1'b0;
      end else if (AVS_WRITE_I && AVS_ADDRESS_I == REG_FANPWR) begin
        fs_count_reg <= fs_timeout_reg; // host refresh restarts the timeout
        fs_div_reg <= 32'h0;
        fs_expired_reg <= 1'b0;
      end else if (fs_mask_reg != 4'h0 && !fs_expired_reg) begin
        if (fs_div_reg == 32'(FS_TICK_CYC - 1)) begin
          fs_div_reg <= 32'h0;
          if (fs_count_reg <= 8'h01) begin
            fs_expired_reg <= 1'b1;
          end else begin
            fs_count_reg <= fs_count_reg - 8'h01;
          end
        end else begin
          fs_div_reg <= fs_div_reg + 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // fan pwm and tach glitch filter, per fan
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_div_reg <= 16'h0;
      pwm_step_reg <= 7'h0;
    end else if (tick) begin
      tick_div_reg <= 16'h0;
      pwm_step_reg <= (pwm_step_reg == 7'(PWM_STEPS - 1)) ? 7'h0 : pwm_step_reg + 7'h1;
    end else begin
      tick_div_reg <= tick_div_reg + 16'h1;
    end
  end

  genvar f;
  generate
    for (f = 0; f < 4; f++) begin : g_fan
      logic [7:0] eff_pwr;
      logic pwm_next;
      logic [7:0] blank_reg;
      logic [15:0] blank_div_reg;
      logic tach_prev_reg;
      assign eff_pwr = (fs_expired_reg && fs_mask_reg[f]) ? PWR_FULL : fan_pwr_reg[f];
      assign pwm_next = {1'b0, pwm_step_reg} < eff_pwr;
      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          fan_pwr_reg[f] <= 8'h0;
          glitch_reg[f] <= GLITCH_RESET;
          FAN_PWM_O[f] <= 1'b0;
          FAN_TACH_EDGE_O[f] <= 1'b0;
          blank_reg <= 8'h0;
          blank_div_reg <= 16'h0;
          tach_prev_reg <= 1'b0;
        end else begin
          if (AVS_WRITE_I && AVS_ADDRESS_I == REG_FANPWR && AVS_BYTEENABLE_I[f]) begin
            fan_pwr_reg[f] <= AVS_WRITEDATA_I[8*f +: 8];
          end
          if (state_reg == ST_EXEC && cmd_reg == CMD_GLITCH && ok) begin
            glitch_reg[f] <= data0_reg[8*f +: 8];
          end
          FAN_PWM_O[f] <= pwm_next;
          tach_prev_reg <= FAN_TACH_I[f];
          // loaded with the turn-on edge itself; own divider so no count is cut short
          if (pwm_next && !FAN_PWM_O[f]) begin
            blank_reg <= glitch_reg[f];
            blank_div_reg <= 16'h0;
          end else if (blank_reg != 8'h0) begin
            if (blank_div_reg == 16'(GLITCH_TICK_CYC - 1)) begin
              blank_div_reg <= 16'h0;
              blank_reg <= blank_reg - 8'h01;
            end else begin
              blank_div_reg <= blank_div_reg + 16'h1;
            end
          end
          FAN_TACH_EDGE_O[f] <= FAN_PWM_O[f] && blank_reg == 8'h0
                                && (FAN_TACH_I[f] != tach_prev_reg);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // power switch lines
  // ---------------------------------------------------------------
  // REG_PULSE write: bit0 start, bit1 selects reset line; REG_CFG bytes 1-2 hold options and length
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      switch_opt_reg <= 8'h01;
      pulse_len_reg <= 8'h20;
    end else if (AVS_WRITE_I && AVS_ADDRESS_I == REG_CFG) begin
      if (AVS_BYTEENABLE_I[1]) begin
        switch_opt_reg <= AVS_WRITEDATA_I[15:8];
      end
      if (AVS_BYTEENABLE_I[2]) begin
        pulse_len_reg <= AVS_WRITEDATA_I[23:16];
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pulse_act_reg <= 1'b0;
      pulse_sel_reg <= 1'b0;
      pulse_cnt_reg <= 8'h0;
      pulse_div_reg <= 32'h0;
      host_sense_reg <= 1'b0;
    end else begin
      if (!pulse_act_reg) begin
        host_sense_reg <= HOST_ON_DETECT_I;
      end
      if (!pulse_act_reg && AVS_WRITE_I && AVS_ADDRESS_I == REG_PULSE && AVS_WRITEDATA_I[0]) begin
        pulse_act_reg <= 1'b1;
        pulse_sel_reg <= AVS_WRITEDATA_I[1];
        pulse_cnt_reg <= pulse_len_reg;
        pulse_div_reg <= 32'h0;
      end else if (pulse_act_reg) begin
        if (pulse_div_reg == 32'(PULSE_TICK_CYC - 1)) begin
          pulse_div_reg <= 32'h0;
          if (pulse_cnt_reg <= 8'h01) begin
            pulse_act_reg <= 1'b0;
          end else begin
            pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
          end
        end else begin
          pulse_div_reg <= pulse_div_reg + 32'h1;
        end
      end
    end
  end

  // auto polarity drives the line opposite to its idle level
  assign SUPPLY_PULSE_OUT_OE_O = pulse_act_reg && !pulse_sel_reg;
  assign RESTART_PULSE_OUT_OE_O = pulse_act_reg && pulse_sel_reg;
  assign SUPPLY_PULSE_OUT_O = switch_opt_reg[AUTO_POL_BIT] ? !host_sense_reg
                                                          : switch_opt_reg[PWR_HIGH_BIT];
  assign RESTART_PULSE_OUT_O = switch_opt_reg[AUTO_POL_BIT] ? !host_sense_reg
                                                           : switch_opt_reg[RST_HIGH_BIT];

endmodule : kfac_top

/* File: verif/kfac_panel_model.sv */
`timescale 1ns/100ps
module kfac_panel_model (
  // clock and stimulus
  input wire logic clk_i,
  input wire logic [5:0] key_target_i,
  input wire logic host_on_i,
  input wire logic [3:0] fan_pwm_i,
  // pins toward the block
  output logic [5:0] keys_o,
  output logic [3:0] tach_o,
  output logic host_sense_o
);
  logic [5:0] cnt_reg = 6'h00;
  always @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 6'h01;
  end
  assign keys_o = key_target_i;
  // unpowered fan: tach floats up on its pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      tach_o[i] = fan_pwm_i[i] ? cnt_reg[5] : 1'b1;
    end
  end
  assign host_sense_o = host_on_i;
endmodule : kfac_panel_model

/* File: verif/kfac_top_monitor.sv */
`timescale 1ns/100ps
module kfac_top_monitor
  import kfac_pkg::*;
(
  // clock and bus
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // keypad, display, fans
  input wire logic LCD_CMD_STB_O,
  input wire logic [5:0] KEY_EVENT_O,
  input wire logic KEY_EVENT_STB_O,
  input wire logic [3:0] FAN_PWM_O,
  input wire logic [3:0] FAN_TACH_EDGE_O,
  // switch lines
  input wire logic SUPPLY_PULSE_OUT_OE_O,
  input wire logic SUPPLY_PULSE_OUT_O,
  input wire logic RESTART_PULSE_OUT_OE_O,
  input wire logic RESTART_PULSE_OUT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic pulse_wr;
  assign pulse_wr = AVS_WRITE_I && AVS_ADDRESS_I == REG_PULSE;
  sequence s_direct_wr;
    AVS_WRITE_I && AVS_ADDRESS_I == REG_CMD && AVS_WRITEDATA_I[7:0] == CMD_DIRECT;
  endsequence
  sequence s_read_answer;
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endsequence
  property p_write_nowait;
    AVS_WRITE_I |-> !AVS_WAITREQUEST_O;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write was stalled");
  property p_read_wait;
    $rose(AVS_READ_I) |-> s_read_answer;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");
  property p_read_stand;
    !AVS_READ_I && !$past(AVS_READ_I) |-> $stable(AVS_READDATA_O);
  endproperty
  a_read_stand: assert property (p_read_stand) else $error("read data moved without a read");
  property p_lcd_cause;
    s_direct_wr |-> ##[1:4] LCD_CMD_STB_O;
  endproperty
  a_lcd_cause: assert property (p_lcd_cause) else $error("direct byte not forwarded");
  property p_lcd_pulse;
    LCD_CMD_STB_O |=> !LCD_CMD_STB_O;
  endproperty
  a_lcd_pulse: assert property (p_lcd_pulse) else $error("display strobe too long");
  property p_key_event;
    KEY_EVENT_STB_O |-> KEY_EVENT_O != 6'h00;
  endproperty
  a_key_event: assert property (p_key_event) else $error("key report with empty mask");
  property p_supply_start;
    $rose(SUPPLY_PULSE_OUT_OE_O) |-> $past(pulse_wr) || $past(pulse_wr, 2);
  endproperty
  a_supply_start: assert property (p_supply_start) else $error("power line driven unasked");
  property p_restart_start;
    $rose(RESTART_PULSE_OUT_OE_O) |-> $past(pulse_wr) || $past(pulse_wr, 2);
  endproperty
  a_restart_start: assert property (p_restart_start) else $error("reset line driven unasked");
  property p_supply_hold;
    SUPPLY_PULSE_OUT_OE_O && $past(SUPPLY_PULSE_OUT_OE_O) |-> $stable(SUPPLY_PULSE_OUT_O);
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("power level moved in pulse");
  property p_tach_quiet;
    $rose(FAN_PWM_O[0]) |=> !FAN_TACH_EDGE_O[0] [*8];
  endproperty
  a_tach_quiet: assert property (p_tach_quiet) else $error("tach edge taken at turn-on");
endmodule : kfac_top_monitor

bind kfac_top kfac_top_monitor u_mon (
  .CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .LCD_CMD_STB_O(LCD_CMD_STB_O), .KEY_EVENT_O(KEY_EVENT_O),
  .KEY_EVENT_STB_O(KEY_EVENT_STB_O), .FAN_PWM_O(FAN_PWM_O), .FAN_TACH_EDGE_O(FAN_TACH_EDGE_O),
  .SUPPLY_PULSE_OUT_OE_O(SUPPLY_PULSE_OUT_OE_O), .SUPPLY_PULSE_OUT_O(SUPPLY_PULSE_OUT_O),
  .RESTART_PULSE_OUT_OE_O(RESTART_PULSE_OUT_OE_O), .RESTART_PULSE_OUT_O(RESTART_PULSE_OUT_O)
);

/* File: verif/kfac_top_test.sv */
`timescale 1ns/100ps
module kfac_top_test;
  import kfac_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] ben = 4'hf;
  logic [5:0] keys_t = 6'h00;
  logic host_on = 1'b0;
  logic [31:0] rdat, q;
  logic wt, lstb, estb, evp, evp_last, exl, so, soe, ro, roe, sense;
  logic [7:0] lcd, lcd_last, b;
  logic [5:0] ev, keys, ev_last;
  logic [3:0] pwm, tach, tedge;
  logic [15:0] lfsr = 16'h002b;
  logic [7:0] op[5] = '{8'h01, 8'h01, 8'h06, 8'h03, 8'h00};
  logic [4:0] ln = 5'b01110;
  logic [4:0] ho = 5'b10010;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int ev_cnt = 0, t0 = 0, t2 = 0;
  int n, down = 0, prs = 0, rel = 0, fs = 0;
  kfac_top u_dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(ben), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt),
    .KEYS_I(keys), .LCD_CMD_O(lcd), .LCD_CMD_STB_O(lstb), .KEY_EVENT_O(ev), .KEY_EVENT_PRESS_O(evp),
    .KEY_EVENT_STB_O(estb), .FAN_PWM_O(pwm), .FAN_TACH_I(tach), .FAN_TACH_EDGE_O(tedge),
    .HOST_ON_DETECT_I(sense), .SUPPLY_PULSE_OUT_O(so), .SUPPLY_PULSE_OUT_OE_O(soe),
    .RESTART_PULSE_OUT_O(ro), .RESTART_PULSE_OUT_OE_O(roe)
  );
  kfac_panel_model u_panel (.clk_i(CLK_I), .key_target_i(keys_t), .host_on_i(host_on), .fan_pwm_i(pwm),
    .keys_o(keys), .tach_o(tach), .host_sense_o(sense));
  always #10 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    if (lstb === 1'b1) lcd_last = lcd;
    if (estb === 1'b1) begin
      ev_cnt++;
      ev_last = ev;
      evp_last = evp;
    end
    if (tedge[0] === 1'b1) t0++;
    if (tedge[2] === 1'b1) t2++;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  task automatic report_and_stop;
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge CLK_I); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic cmd(input logic [7:0] c, input logic [31:0] args, input logic [7:0] e);
    int k;
    bus(1'b1, REG_DATA0, args);
    bus(1'b1, REG_CMD, {24'h0, c});
    repeat (3) @(posedge CLK_I);
    k = 0;
    do begin
      bus(1'b0, REG_RSP, 32'h0);
      k++;
    end while (q[8] !== 1'b1 && k < 20);
    chk(32'(q[8:0]), 32'({1'b1, e}));
  endtask : cmd
  task automatic press(input logic [5:0] m);
    @(posedge CLK_I);
    keys_t <= m;
    prs = prs | (m & ~down);
    rel = rel | (down & ~m);
    down = m;
    repeat (8) @(posedge CLK_I);
  endtask : press
  task automatic poll;
    cmd(CMD_POLL, 32'h0, 8'h58);
    bus(1'b0, REG_RDAT0, 32'h0);
    chk(32'(q[23:0]), 32'({8'(rel), 8'(prs), 8'(down)}));
    prs = 0;
    rel = 0;
  endtask : poll
  initial begin
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    // boot state and unmapped place
    bus(1'b0, REG_KEYS, 32'h0);
    chk(32'(q[13:8]), 32'h3f);
    bus(1'b0, REG_CFG, 32'h0);
    chk(32'(q[5:0]), 32'h3f);
    bus(1'b0, REG_SAVE, 32'h0);
    chk(q, 32'h01010101);
    bus(1'b1, 6'h3c, 32'hffffffff);
    bus(1'b0, 6'h3c, 32'h0);
    chk(q, 32'h0);
    // unsolicited reports, then masked per key
    press(KEY_UP_BIT);
    chk(ev_cnt, 1);
    chk(32'(ev_last), 32'(KEY_UP_BIT));
    chk(32'(evp_last), 32'h1);
    press(6'h00);
    chk(ev_cnt, 2);
    chk(32'(evp_last), 32'h0);
    cmd(CMD_KEYREP, {16'h0, 8'h00, 8'h02}, 8'h57);
    cmd(CMD_KEYREP, {16'h0, 8'h40, 8'h01}, RSP_ERROR);
    bus(1'b0, REG_KEYS, 32'h0);
    chk(32'(q[13:8]), 32'(KEY_CONFIRM_BIT));
    press(6'h03);
    press(6'h00);
    chk(ev_cnt, 3);
    chk(32'(ev_last), 32'(KEY_CONFIRM_BIT));
    poll();
    // polled mode with reports off
    cmd(CMD_KEYREP, 32'h0, 8'h57);
    for (int i = 0; i < 4; i++) begin
      press(6'(rnd()));
      press(6'(rnd()));
      poll();
    end
    chk(ev_cnt, 3);
    for (int i = 0; i < 3; i++) begin
      b = rnd();
      cmd(CMD_DIRECT, {24'h0, b}, 8'h56);
      chk(32'(lcd_last), 32'(b));
    end
    // fans
    b = 8'(rnd() % 101);
    bus(1'b1, REG_FANPWR, {b, 8'h32, 8'h00, PWR_FULL});
    foreach (op[i]) begin
      n = (i == 0) ? 32'h05 : ((i == 1) ? 32'h00 : 32'h10);
      cmd(CMD_FAILSAFE, {16'h0, 8'h01, 8'(n)}, (i == 0) ? 8'h59 : RSP_ERROR);
      if (i == 0) fs = n;
      cmd(CMD_FANQ, 32'h0, 8'h5b);
      bus(1'b0, REG_RDAT1, 32'h0);
      chk(32'(q[7:0]), fs);
      bus(1'b0, REG_RDAT0, 32'h0);
      chk(q, {b, 8'h32, 8'h00, PWR_FULL});
    end
    chk(32'(pwm[1:0]), 32'h1);
    cmd(CMD_GLITCH, 32'h32006401, 8'h5a);
    cmd(CMD_GLITCH, 32'h00650101, RSP_ERROR);
    bus(1'b0, REG_SAVE, 32'h0);
    chk(q, 32'h32006401);
    // fresh turn-on of fan three with no delay; fan one stays blanked all run
    ben <= 4'b0100;
    bus(1'b1, REG_FANPWR, 32'h0);
    bus(1'b1, REG_FANPWR, {8'h00, PWR_FULL, 16'h0});
    ben <= 4'hf;
    repeat (8) @(posedge CLK_I);
    @(negedge CLK_I);
    n = t2;
    repeat (128) @(negedge CLK_I);
    chk(t2 - n, 4);
    chk(t0, 0);
    @(posedge CLK_I);
    // switch pulses, each case ended by a reset
    chk(32'({soe, roe}), 32'h0);
    foreach (op[i]) begin
      host_on <= ho[i];
      ben <= 4'b0010;
      bus(1'b1, REG_CFG, {16'h0, op[i], 8'h00});
      ben <= 4'hf;
      bus(1'b1, REG_PULSE, {30'h0, ln[i], 1'b1});
      bus(1'b0, REG_PULSE, 32'h0);
      chk(32'(q[1:0]), 32'({ln[i], 1'b1}));
      chk(32'({soe, roe}), ln[i] ? 32'h1 : 32'h2);
      exl = op[i][AUTO_POL_BIT] ? !ho[i] : op[i][ln[i] ? RST_HIGH_BIT : PWR_HIGH_BIT];
      chk(32'(ln[i] ? ro : so), 32'(exl));
      @(posedge CLK_I);
      RST_I <= 1'b1;
      repeat (4) @(posedge CLK_I);
      RST_I <= 1'b0;
      chk(32'({soe, roe}), 32'h0);
    end
    report_and_stop();
  end
endmodule : kfac_top_test
